// >>> sensor_control_pad_logic.sv
`timescale 1ns/1ps
module sensor_control_pad_logic
  import pad_pkg::*;
(
  // clock and resets
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hard_reset_n,
  // configuration from the register core
  input wire pad_cfg_type cfg,
  input wire logic flash_req,
  input wire logic shutter_req,
  input wire logic chain_out_req,
  // general pin a, three-signal pad
  input wire logic general_pin_a_in,
  output logic general_pin_a_out,
  output logic general_pin_a_oe_n,
  // general pin b, three-signal pad
  input wire logic general_pin_b_in,
  output logic general_pin_b_out,
  output logic general_pin_b_oe_n,
  // general inputs
  input wire logic general_input_c,
  input wire logic general_input_d,
  output logic input_c_powered,
  output logic input_d_powered,
  // recovered input functions
  output in_funcs_type in_funcs,
  // two-wire serial register bus pads
  input wire logic serial_clock,
  input wire logic register_serial_data_in,
  input wire logic register_serial_data_drive,
  input wire logic register_serial_data_bit,
  output logic register_serial_data_out,
  output logic register_serial_data_oe_n,
  output logic serial_clock_rise,
  output logic serial_data_sync,
  // image lanes
  input wire logic [LANE_MAX-1:0] lane_data,
  input wire logic lane_clk_in,
  output logic [LANE_MAX-1:0] lane_out,
  output logic [LANE_MAX-1:0] lane_enable,
  output logic lane_clk_out,
  // power state
  output logic digital_power_on,
  output logic core_rst
);

  logic arst;
  logic [1:0] rel_sync_r;
  logic core_run;
  logic [1:0] a_sync_r, b_sync_r, c_sync_r, d_sync_r;
  logic [1:0] scl_sync_r, sda_sync_r;
  logic scl_prev_r;
  logic a_val, b_val, c_val, d_val;
  in_funcs_type funcs_nxt;

  // either reset source
  // async hard reset
  assign arst = rst | ~hard_reset_n;

  // release synchroniser for either reset
  // synced reset release
  always_ff @(posedge ref_clk or posedge arst) begin
    if (arst) begin
      rel_sync_r <= 2'h0;
    end else begin
      rel_sync_r <= {rel_sync_r[0], 1'b1};
    end
  end
  assign core_run = rel_sync_r[1];
  assign core_rst = ~core_run;

  // digital domain on only after reset release
  // power off in reset
  assign digital_power_on = core_run;

  // pad input synchronisers
  always_ff @(posedge ref_clk or posedge arst) begin
    if (arst) begin
      a_sync_r <= 2'h0;
      b_sync_r <= 2'h0;
      c_sync_r <= 2'h0;
      d_sync_r <= 2'h0;
    end else begin
      a_sync_r <= {a_sync_r[0], general_pin_a_in};
      b_sync_r <= {b_sync_r[0], general_pin_b_in};
      c_sync_r <= {c_sync_r[0], general_input_c};
      d_sync_r <= {d_sync_r[0], general_input_d};
    end
  end

  // powered-down inputs read as zero
  // inputs c d off
  assign c_val = c_sync_r[1] & cfg.c_enable;
  assign d_val = d_sync_r[1] & cfg.d_enable;
  assign a_val = a_sync_r[1] & (cfg.a_mode == PA_INPUT);
  assign b_val = b_sync_r[1] & (cfg.b_mode == PB_INPUT);
  assign input_c_powered = core_run & cfg.c_enable;
  assign input_d_powered = core_run & cfg.d_enable;

  // route one pad level to its chosen function
  function automatic in_funcs_type route(input logic v, input in_func_type f);
    in_funcs_type r;
    r = '0;
    case (f)
      IN_ADDR_SEL: r.addr_sel = v;
      IN_TRIGGER: r.trigger = v;
      IN_STANDBY: r.standby_req = v;
      default: r = '0;
    endcase
    return r;
  endfunction : route

  // merge every input-capable pad
  // input a b c d functions
  always_comb begin
    funcs_nxt = route(c_val, cfg.c_func);
    funcs_nxt = funcs_nxt | route(a_val, cfg.a_func);
    funcs_nxt = funcs_nxt | route(b_val, cfg.b_func);
    if (cfg.d_mode == PD_CHAIN_IN) begin
      funcs_nxt.chain_in = d_val;
    end else begin
      funcs_nxt = funcs_nxt | route(d_val, cfg.d_func);
    end
  end

  // registered function outputs
  always_ff @(posedge ref_clk or posedge arst) begin
    if (arst) begin
      in_funcs <= '0;
    end else begin
      in_funcs <= funcs_nxt;
    end
  end

  // pin a output: flash by default, high-z until released
  // high-z then zero
  always_ff @(posedge ref_clk or posedge arst) begin
    if (arst) begin
      general_pin_a_out <= PAD_DEFAULT;
      general_pin_a_oe_n <= 1'b1;
    end else if (!core_run) begin
      general_pin_a_out <= PAD_DEFAULT;
      general_pin_a_oe_n <= 1'b1;
    end else begin
      general_pin_a_out <= (cfg.a_mode == PA_FLASH_OUT) & flash_req;
      general_pin_a_oe_n <= (cfg.a_mode == PA_INPUT);
    end
  end

  // pin b output: shutter by default, or chain output
  // pin b select
  always_ff @(posedge ref_clk or posedge arst) begin
    if (arst) begin
      general_pin_b_out <= PAD_DEFAULT;
      general_pin_b_oe_n <= 1'b1;
    end else if (!core_run) begin
      general_pin_b_out <= PAD_DEFAULT;
      general_pin_b_oe_n <= 1'b1;
    end else begin
      case (cfg.b_mode)
        PB_SHUTTER_OUT: general_pin_b_out <= shutter_req;
        PB_CHAIN_OUT: general_pin_b_out <= chain_out_req;
        default: general_pin_b_out <= PAD_DEFAULT;
      endcase
      general_pin_b_oe_n <= (cfg.b_mode == PB_INPUT);
    end
  end

  // serial bus pad sampling
  // serial bus pads
  always_ff @(posedge ref_clk or posedge arst) begin
    if (arst) begin
      // idle bus level is high: no false clock edge after reset
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      scl_prev_r <= 1'b1;
    end else begin
      scl_sync_r <= {scl_sync_r[0], serial_clock};
      sda_sync_r <= {sda_sync_r[0], register_serial_data_in};
      scl_prev_r <= scl_sync_r[1];
    end
  end
  assign serial_clock_rise = scl_sync_r[1] & ~scl_prev_r;
  assign serial_data_sync = sda_sync_r[1];

  // open-drain data: only ever pulls low
  always_ff @(posedge ref_clk or posedge arst) begin
    if (arst) begin
      register_serial_data_out <= 1'b0;
      register_serial_data_oe_n <= 1'b1;
    end else begin
      register_serial_data_out <= 1'b0;
      register_serial_data_oe_n <= ~(core_run & register_serial_data_drive
                                     & ~register_serial_data_bit);
    end
  end

  // lane count to enable mask
  function automatic logic [LANE_MAX-1:0] lane_mask(input logic [1:0] c);
    case (c)
      LANES_2: lane_mask = 4'h3;
      LANES_3: lane_mask = 4'h7;
      LANES_4: lane_mask = 4'hf;
      default: lane_mask = 4'hf;
    endcase
  endfunction : lane_mask

  // image lanes, silenced at once by reset
  // four lanes plus clock
  always_ff @(posedge ref_clk or posedge arst) begin
    if (arst) begin
      lane_out <= '0;
      lane_enable <= '0;
      lane_clk_out <= 1'b0;
    end else begin
      lane_enable <= core_run ? lane_mask(cfg.lane_cfg) : '0;
      lane_out <= core_run ? (lane_data & lane_mask(cfg.lane_cfg)) : '0;
      lane_clk_out <= core_run & lane_clk_in;
    end
  end

  // pads float until the release has passed the synchroniser
  pads_float_a: assert property (
    @(posedge ref_clk) disable iff (arst)
    !core_run |-> (general_pin_a_oe_n && general_pin_b_oe_n))
    else $error("pad driven before reset release");

  // first edge after release drives zero on pin a in flash mode
  pads_zero_a: assert property (
    @(posedge ref_clk) disable iff (arst)
    ($rose(core_run) && cfg.a_mode == PA_FLASH_OUT && !flash_req)
      |=> (!general_pin_a_oe_n && !general_pin_a_out))
    else $error("pin a not driving zero after release");

  // flash follows its request one cycle later
  flash_follow_a: assert property (
    @(posedge ref_clk) disable iff (arst)
    (core_run && cfg.a_mode == PA_FLASH_OUT) |=> general_pin_a_out ==
      $past(flash_req))
    else $error("flash output wrong");

  // shutter follows its request
  shutter_follow_a: assert property (
    @(posedge ref_clk) disable iff (arst)
    (core_run && cfg.b_mode == PB_SHUTTER_OUT)
      |=> (general_pin_b_out == $past(shutter_req) && !general_pin_b_oe_n))
    else $error("shutter output wrong");

  // with inputs c d disabled and pins a b not inputs, no function is set
  c_off_a: assert property (
    @(posedge ref_clk) disable iff (arst)
    (!cfg.c_enable && !cfg.d_enable && cfg.a_mode != PA_INPUT
      && cfg.b_mode != PB_INPUT) |=> in_funcs == '0)
    else $error("powered-down input leaked");

  // input c standby path, three cycles from pin
  c_standby_a: assert property (
    @(posedge ref_clk) disable iff (arst)
    (cfg.c_enable && cfg.c_func == IN_STANDBY && c_sync_r[1])
      |=> in_funcs.standby_req)
    else $error("standby request missed");

  // input d chain path
  d_chain_a: assert property (
    @(posedge ref_clk) disable iff (arst)
    (cfg.d_mode == PD_CHAIN_IN)
      |=> in_funcs.chain_in == $past(d_val))
    else $error("chain input wrong");

  // lanes beyond a two-lane count stay quiet
  lane_mask_a: assert property (
    @(posedge ref_clk) disable iff (arst)
    (core_run && cfg.lane_cfg == LANES_2) |=> lane_enable[3:2] == 2'h0)
    else $error("unused lane enabled");

  // power stays off while either reset is held
  power_track_a: assert property (
    @(posedge ref_clk)
    (rst || !hard_reset_n) |-> (!digital_power_on && core_rst))
    else $error("power on during reset");

endmodule : sensor_control_pad_logic

// >>> pad_pkg.sv
package pad_pkg;
  // general pin a functions
  typedef enum logic [1:0] {
    PA_FLASH_OUT,
    PA_INPUT
  } pin_a_mode_type;
  // general pin b functions
  typedef enum logic [1:0] {
    PB_SHUTTER_OUT,
    PB_CHAIN_OUT,
    PB_INPUT
  } pin_b_mode_type;
  // input functions shared by all input-capable pads
  typedef enum logic [1:0] {
    IN_ADDR_SEL,
    IN_TRIGGER,
    IN_STANDBY
  } in_func_type;
  // general input d functions
  typedef enum logic [0:0] {
    PD_CHAIN_IN,
    PD_GENERAL
  } pin_d_mode_type;
  // lane count codes
  localparam logic [1:0] LANES_2 = 2'h0;
  localparam logic [1:0] LANES_3 = 2'h1;
  localparam logic [1:0] LANES_4 = 2'h2;
  localparam int LANE_MAX = 4;
  // pad output level held in reset and until reset release
  localparam logic PAD_DEFAULT = 1'b0;
  // master clock range, in kHz
  localparam int MCLK_MIN_KHZ = 6000;
  localparam int MCLK_MAX_KHZ = 27000;
  // pad configuration travelling together
  typedef struct packed {
    pin_a_mode_type a_mode;
    pin_b_mode_type b_mode;
    logic c_enable;
    logic d_enable;
    pin_d_mode_type d_mode;
    in_func_type a_func;
    in_func_type b_func;
    in_func_type c_func;
    in_func_type d_func;
    logic [1:0] lane_cfg;
  } pad_cfg_type;
  // functions recovered from the input pads
  typedef struct packed {
    logic addr_sel;
    logic trigger;
    logic standby_req;
    logic chain_in;
  } in_funcs_type;
endpackage : pad_pkg

// >>> serial_host_model.sv
`timescale 1ns/1ps
module serial_host_model (
  // frame control
  input wire logic start,
  // two-wire lines
  output logic serial_clock,
  output logic host_pull_low
);
  // idle bus: clock parked high, data released to pull-up
  initial begin
    serial_clock = 1'b1;
    host_pull_low = 1'b0;
  end
  always @(posedge start) begin
    for (int i = 0; i < 9; i++) begin
      #40 serial_clock = 1'b0;
      host_pull_low = i[0];
      #80 serial_clock = 1'b1;
      #40;
    end
    host_pull_low = 1'b0;
  end
endmodule : serial_host_model

// >>> tb_sensor_control_pad_logic.sv
`timescale 1ns/1ps
module tb_sensor_control_pad_logic;
  import pad_pkg::*;
  logic ref_clk, rst, hard_reset_n, flash_req, shutter_req, chain_out_req;
  logic pa_in, pb_in, pin_c, pin_d, sd_drive, sd_bit, lane_clk_in, start;
  logic pa_out, pa_oe_n, pb_out, pb_oe_n, c_pw, d_pw, sd_out, sd_oe_n;
  logic sclk_rise, sd_sync, lane_clk_out, dig_on, core_rst, sclk, host_low;
  logic [LANE_MAX-1:0] lane_data, lane_out, lane_en;
  pad_cfg_type cfg;
  in_funcs_type funcs;
  int num_errors = 0;
  int n_tests = 0;
  int rises = 0;
  logic [31:0] seed = 32'h19c5047e;
  // open-drain data line with pull-up
  wire sda_line = ~(host_low | ~sd_oe_n);

  sensor_control_pad_logic u_sensor_control_pad_logic (
    .ref_clk(ref_clk), .rst(rst), .hard_reset_n(hard_reset_n), .cfg(cfg),
    .flash_req(flash_req), .shutter_req(shutter_req),
    .chain_out_req(chain_out_req), .general_pin_a_in(pa_in),
    .general_pin_a_out(pa_out), .general_pin_a_oe_n(pa_oe_n),
    .general_pin_b_in(pb_in), .general_pin_b_out(pb_out),
    .general_pin_b_oe_n(pb_oe_n), .general_input_c(pin_c),
    .general_input_d(pin_d), .input_c_powered(c_pw),
    .input_d_powered(d_pw), .in_funcs(funcs), .serial_clock(sclk),
    .register_serial_data_in(sda_line),
    .register_serial_data_drive(sd_drive),
    .register_serial_data_bit(sd_bit), .register_serial_data_out(sd_out),
    .register_serial_data_oe_n(sd_oe_n), .serial_clock_rise(sclk_rise),
    .serial_data_sync(sd_sync), .lane_data(lane_data),
    .lane_clk_in(lane_clk_in), .lane_out(lane_out), .lane_enable(lane_en),
    .lane_clk_out(lane_clk_out), .digital_power_on(dig_on),
    .core_rst(core_rst));

  serial_host_model u_serial_host_model (
    .start(start), .serial_clock(sclk), .host_pull_low(host_low));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // count serial clock edges seen by the block
  always @(negedge ref_clk) begin
    if (sclk_rise === 1'b1) rises++;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic [3:0] lane_mask(logic [1:0] c);
    return (c == LANES_2) ? 4'h3 : (c == LANES_3) ? 4'h7 : 4'hf;
  endfunction : lane_mask
  function automatic in_funcs_type func_exp(in_func_type f);
    in_funcs_type e;
    e = '0;
    e.addr_sel = (f == IN_ADDR_SEL);
    e.trigger = (f == IN_TRIGGER);
    e.standby_req = (f == IN_STANDBY);
    return e;
  endfunction : func_exp
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_funcs(in_funcs_type got, in_funcs_type exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_funcs
  task automatic cyc(int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc
  task automatic stop_test();
    $display("checks=%0d errors=%0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  // watchdog
  initial begin
    #50000;
    num_errors++;
    stop_test();
  end

  // main sequence
  initial begin
    {rst, hard_reset_n, flash_req, shutter_req, chain_out_req} = 5'h10;
    {pa_in, pb_in, pin_c, pin_d, sd_drive, sd_bit, lane_clk_in} = '0;
    {start, lane_data} = '0;
    cfg = '0;
    cyc(8);
    chk(8'({pa_oe_n, pb_oe_n}), 8'h3);
    chk(8'(dig_on), 8'h0);
    chk(8'(lane_out), 8'h0);
    rst = 1'b0;
    hard_reset_n = 1'b1;
    cyc(1);
    chk(8'(pa_oe_n), 8'h1);
    cyc(3);
    chk(8'({pa_oe_n, pb_oe_n, pa_out, pb_out}), 8'h0);
    chk(8'(dig_on), 8'h1);
    chk(8'({c_pw, d_pw}), 8'h0);
    {pin_c, pin_d} = 2'h3;
    cyc(4);
    chk_funcs(funcs, '0);
    for (int i = 0; i < 8; i++) begin
      {flash_req, shutter_req} = 2'(xs());
      cyc(1);
      chk(8'({pa_out, pb_out}), 8'({flash_req, shutter_req}));
    end
    cfg.b_mode = PB_CHAIN_OUT;
    chain_out_req = 1'b1;
    shutter_req = 1'b0;
    cyc(2);
    chk(8'(pb_out), 8'h1);
    for (int p = 0; p < 4; p++) begin
      for (int f = 0; f < 3; f++) begin
        cfg.a_mode = (p == 0) ? PA_INPUT : PA_FLASH_OUT;
        cfg.b_mode = (p == 1) ? PB_INPUT : PB_SHUTTER_OUT;
        {cfg.c_enable, cfg.d_enable} = {p == 2, p == 3};
        cfg.d_mode = PD_GENERAL;
        cfg.a_func = in_func_type'(f);
        {cfg.b_func, cfg.c_func, cfg.d_func} = {3{in_func_type'(f)}};
        {pa_in, pb_in, pin_c, pin_d} = 4'h8 >> p;
        cyc(4);
        chk_funcs(funcs, func_exp(in_func_type'(f)));
        chk(8'({c_pw, d_pw}), 8'({p == 2, p == 3}));
        chk(8'({pa_oe_n, pb_oe_n}), 8'({p == 0, p == 1}));
      end
    end
    cfg.d_mode = PD_CHAIN_IN;
    cyc(4);
    chk_funcs(funcs, in_funcs_type'(4'h1));
    for (int c = 0; c < 4; c++) begin
      cfg.lane_cfg = c[1:0];
      lane_data = 4'(xs());
      lane_clk_in = 1'(xs());
      cyc(2);
      chk(8'(lane_en), 8'(lane_mask(c[1:0])));
      chk(8'(lane_out), 8'(lane_data & lane_mask(c[1:0])));
      chk(8'(lane_clk_out), 8'(lane_clk_in));
    end
    rises = 0;
    start = 1'b1;
    cyc(160);
    chk(8'(rises), 8'h9);
    chk(8'(sd_sync), 8'h1);
    sd_drive = 1'b1;
    cyc(4);
    chk(8'({sd_out, sd_oe_n, sd_sync}), 8'h0);
    sd_drive = 1'b0;
    lane_data = 4'hf;
    cyc(2);
    hard_reset_n = 1'b0;
    #1;
    chk(8'({lane_out, pa_oe_n}), 8'h01);
    chk(8'({dig_on, core_rst}), 8'h1);
    chk_funcs(funcs, '0);
    cyc(2);
    hard_reset_n = 1'b1;
    cyc(4);
    chk(8'(lane_out), 8'hf);
    chk(8'(rises), 8'h9);
    stop_test();
  end
endmodule : tb_sensor_control_pad_logic
